// ==== inc/pidc_cfg.svh ====
// constants for the pid loop calculation unit
//
// What this block does
// - step bias: direct loop scales bias by new/old setpoint, reverse by old/new
// - reset time of 9999 removes integral action; bias then set by software
// - derivative time of zero removes derivative action entirely
// - integral coef gain*Ts/Ti, derivative coef gain*Td/Ts; zero gain drops the gain
// - velocity form gives per-sample output change, current minus previous output
// - manual to automatic loads setpoint with process value; position form loads bias
// - two bumpless transfer variants, chosen per loop in the control register
// - separate high-high, high, low and low-low process value limit alarms
// - yellow and larger orange deviation alarms, in either direction
// - rate alarm when process value changes faster than configured limit
// - limit and deviation alarms set beyond threshold (low limits below it), with hysteresis on release
// - manual mode outputs operator value while all alarms keep running
// - automatic mode computes output from stored parameters and evaluates alarms
// - cascade mode acts as automatic but takes setpoint from another loop
// - reverse acting negates integral and proportional terms and derivative sign
// - square root option takes root of process value before the calculation
// - error squaring forms error times its own absolute value
// - deadband gives zero error inside a symmetric band around the setpoint
// - with both selected squaring comes first, deadband test afterwards
// - derivative gain limiting low-passes process value with gain Ts/(Ts+Td/Kd)
// - computed (non-manual) output clamped to 0.0 to 1.0; manual mode passes the operator value unclamped
// - output is gain*e minus derivative coef*change plus bias; bias accumulates
// - freeze option holds bias while computed output lies outside zero to one
// - otherwise, unless reset time is 9999, on saturation bias becomes clamped output minus p and d terms
`ifndef PIDC_CFG_SVH
`define PIDC_CFG_SVH

// register byte offsets
`define PIDC_OFS_CTRL      8'h00
`define PIDC_OFS_SETPOINT  8'h04
`define PIDC_OFS_GAIN      8'h08
`define PIDC_OFS_TS        8'h0C
`define PIDC_OFS_TI        8'h10
`define PIDC_OFS_TD        8'h14
`define PIDC_OFS_KD        8'h18
`define PIDC_OFS_BIAS      8'h1C
`define PIDC_OFS_MANUAL    8'h20
`define PIDC_OFS_HH        8'h24
`define PIDC_OFS_H         8'h28
`define PIDC_OFS_L         8'h2C
`define PIDC_OFS_LL        8'h30
`define PIDC_OFS_YELLOW    8'h34
`define PIDC_OFS_ORANGE    8'h38
`define PIDC_OFS_RATE      8'h3C
`define PIDC_OFS_HYST      8'h40
`define PIDC_OFS_DBAND     8'h44
`define PIDC_OFS_OUTPUT    8'h48
`define PIDC_OFS_INCR      8'h4C
`define PIDC_OFS_STATUS    8'h50
`define PIDC_REG_COUNT     21

// control register fields
`define PIDC_CTL_ENABLE    0
`define PIDC_CTL_MODE_LO   1
`define PIDC_CTL_REVERSE   3
`define PIDC_CTL_VELOCITY  4
`define PIDC_CTL_FREEZE    5
`define PIDC_CTL_STEPBIAS  6
`define PIDC_CTL_SQRT      7
`define PIDC_CTL_ERRSQ     8
`define PIDC_CTL_DBAND     9
`define PIDC_CTL_DGL       10
`define PIDC_CTL_VARIANT   11
`define PIDC_STS_BUSY      8

// numbers: q16.16 fixed point, 1.0 = 0x0001_0000
`define PIDC_ONE           32'h0001_0000
`define PIDC_TI_OFF        32'h0000_270F
`define PIDC_RST_TS        32'h0000_0001
`define PIDC_RST_TI        32'h0000_270F
`define PIDC_RST_KD        32'h0001_0000
`define PIDC_DIV_STEPS     6'h2F
`define PIDC_SQRT_STEPS    6'h0F

// sample time unit 1 ms at a 5 ns clock
`define PIDC_TICK_NS       1000000
`define PIDC_CLK_NS        5

`endif

// ==== inc/pidc_pkg.sv ====
// types of the pid loop calculation unit
`default_nettype none
package pidc_pkg;

	typedef enum logic [1:0] {
		PIDC_MANUAL  = 2'b00,
		PIDC_AUTO    = 2'b01,
		PIDC_CASCADE = 2'b10
	} pidc_mode_e;

	typedef enum logic [2:0] {
		PIDC_ST_IDLE = 3'b000,
		PIDC_ST_STEP = 3'b001,
		PIDC_ST_KI   = 3'b010,
		PIDC_ST_KR   = 3'b011,
		PIDC_ST_TDKD = 3'b100,
		PIDC_ST_FG   = 3'b101,
		PIDC_ST_SQRT = 3'b110,
		PIDC_ST_CALC = 3'b111
	} pidc_state_e;

	typedef struct packed {
		logic [20:0][31:0] regs;
		logic              ack;
		logic [31:0]       rdata;
		logic [31:0]       tick;
		logic [31:0]       scnt;
		pidc_state_e       st;
		logic              busy;
		logic [5:0]        cnt;
		logic [47:0]       num;
		logic [32:0]       rem;
		logic [31:0]       den;
		logic [31:0]       ki;
		logic [31:0]       kr;
		logic [31:0]       tdkd;
		logic [31:0]       fg;
		logic [31:0]       pv;
		logic [31:0]       pv_prev;
		logic [31:0]       y_prev;
		logic [31:0]       sp_prev;
		logic [1:0]        mode_prev;
		logic              done;
	} pidc_state_s;

endpackage
`default_nettype wire

// ==== verilog/pidc_loop_calc.sv ====
// pid loop calculation unit with avalon-mm register slave
//
// The register addresses and register access over Avalon-MM were left to the implementer.
`include "pidc_cfg.svh"
`default_nettype none
module pidc_loop_calc #(
	parameter int unsigned TICK_CYCLES = `PIDC_TICK_NS / `PIDC_CLK_NS
) (
	input  wire logic        ref_clk_i,            // 200 mhz clock
	input  wire logic        sys_rst_i,            // synchronous reset, high
	input  wire logic [7:0]  avs_address_i,        // byte address
	input  wire logic        avs_read_i,           // read request
	input  wire logic        avs_write_i,          // write request
	input  wire logic [31:0] avs_writedata_i,      // write data
	input  wire logic [3:0]  avs_byteenable_i,     // byte lanes
	output logic      [31:0] avs_readdata_o,       // read data
	output logic             avs_waitrequest_o,    // stall
	input  wire logic [15:0] process_value_i,      // pv, unsigned fraction of 1.0
	input  wire logic [31:0] cascade_setpoint_i,   // other loop output, q16.16
	output logic      [31:0] control_output_o,     // position output, q16.16
	output logic      [31:0] output_increment_o,   // velocity output, q16.16
	output logic      [6:0]  alarms_o,             // hh h l ll yellow orange rate
	output logic             sample_done_o         // one pulse per calculation
);

	localparam int CTRL = `PIDC_OFS_CTRL >> 2;
	localparam int SP   = `PIDC_OFS_SETPOINT >> 2;
	localparam int KC   = `PIDC_OFS_GAIN >> 2;
	localparam int TS   = `PIDC_OFS_TS >> 2;
	localparam int TI   = `PIDC_OFS_TI >> 2;
	localparam int TD   = `PIDC_OFS_TD >> 2;
	localparam int KD   = `PIDC_OFS_KD >> 2;
	localparam int BIAS = `PIDC_OFS_BIAS >> 2;
	localparam int MAN  = `PIDC_OFS_MANUAL >> 2;
	localparam int HH   = `PIDC_OFS_HH >> 2;
	localparam int HI   = `PIDC_OFS_H >> 2;
	localparam int LO   = `PIDC_OFS_L >> 2;
	localparam int LL   = `PIDC_OFS_LL >> 2;
	localparam int YEL  = `PIDC_OFS_YELLOW >> 2;
	localparam int ORA  = `PIDC_OFS_ORANGE >> 2;
	localparam int RATE = `PIDC_OFS_RATE >> 2;
	localparam int HYS  = `PIDC_OFS_HYST >> 2;
	localparam int DBND = `PIDC_OFS_DBAND >> 2;
	localparam int OUTR = `PIDC_OFS_OUTPUT >> 2;
	localparam int INCR = `PIDC_OFS_INCR >> 2;
	localparam int STS  = `PIDC_OFS_STATUS >> 2;

	////////////////////////////////////////////////////////////////////////////
	// arithmetic helpers

	function automatic logic signed [31:0] qmul(input logic signed [31:0] a,
		input logic signed [31:0] b);
		logic signed [63:0] p;
		p = a * b;
		qmul = p[47:16];
	endfunction

	function automatic logic signed [31:0] qabs(input logic signed [31:0] a);
		qabs = a[31] ? -a : a;
	endfunction

	function automatic logic signed [31:0] clamp01(input logic signed [31:0] a);
		if (a < 0)
			clamp01 = '0;
		else if (a > $signed(`PIDC_ONE))
			clamp01 = `PIDC_ONE;
		else
			clamp01 = a;
	endfunction

	// alarm above threshold; once set it holds until value drops a hysteresis below
	function automatic logic over(input logic prev, input logic signed [31:0] v,
		input logic signed [31:0] thr, input logic signed [31:0] hys);
		over = prev ? (v > thr - hys) : (v > thr);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i])
				r[i*8 +: 8] = wd[i*8 +: 8];
		end
		merge = r;
	endfunction

	// mode field, read in several places
	function automatic logic [1:0] mode_of(input logic [31:0] c);
		mode_of = c[`PIDC_CTL_MODE_LO +: 2];
	endfunction

	// last cycle of a pacing tick
	function automatic logic tick_end(input logic [31:0] t);
		tick_end = t == TICK_CYCLES - 1;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// state

	// every register of the block sits in this one record
	pidc_pkg::pidc_state_s s_r;
	pidc_pkg::pidc_state_s s_nxt;

	logic [31:0] ctl;
	logic        req;
	logic [5:0]  idx;
	logic [31:0] sp_eff;
	logic        skip;
	logic [31:0] da;
	logic [31:0] db;
	logic [32:0] rem_sh;
	logic [47:0] num_sh;
	logic [31:0] quo;
	logic [15:0] cand;
	logic [31:0] sq;
	logic signed [31:0] err_raw, e1, e, kc, ki, kr, y, dy, dev;
	logic signed [31:0] pterm, iterm, dterm, bias_i, m, pd, outv, bias_n;
	logic [6:0]  al;

	assign ctl                = s_r.regs[CTRL];
	assign req                = avs_read_i | avs_write_i;
	assign idx                = avs_address_i[7:2];
	// every access costs exactly one wait cycle
	assign avs_waitrequest_o  = req & ~s_r.ack;
	assign avs_readdata_o     = s_r.rdata;
	assign control_output_o   = s_r.regs[OUTR];
	assign output_increment_o = s_r.regs[INCR];
	assign alarms_o           = s_r.regs[STS][6:0];
	assign sample_done_o      = s_r.done;

	// cascade takes its setpoint from the other loop's output
	assign sp_eff = (mode_of(ctl) == pidc_pkg::PIDC_CASCADE) ?
		cascade_setpoint_i : s_r.regs[SP];

	////////////////////////////////////////////////////////////////////////////
	// shared divider operands, quotient = (a << 16) / b, saturating
	// one bit a cycle: a single subtractor, 49 cycles per ratio

	always_comb begin
		da   = '0;
		db   = '0;
		skip = 1'b0;
		case (s_r.st)
			pidc_pkg::PIDC_ST_STEP: begin
				skip = !ctl[`PIDC_CTL_STEPBIAS] || ctl[`PIDC_CTL_FREEZE] ||
					sp_eff == s_r.sp_prev || sp_eff == '0 || s_r.sp_prev == '0;
				da = ctl[`PIDC_CTL_REVERSE] ? s_r.sp_prev : sp_eff;
				db = ctl[`PIDC_CTL_REVERSE] ? sp_eff : s_r.sp_prev;
			end
			pidc_pkg::PIDC_ST_KI: begin
				skip = s_r.regs[TI] == `PIDC_TI_OFF;
				da   = s_r.regs[TS];
				db   = s_r.regs[TI];
			end
			pidc_pkg::PIDC_ST_KR: begin
				skip = s_r.regs[TD] == '0;
				da   = s_r.regs[TD];
				db   = s_r.regs[TS];
			end
			pidc_pkg::PIDC_ST_TDKD: begin
				skip = !ctl[`PIDC_CTL_DGL];
				da   = {s_r.regs[TD][15:0], 16'h0000};
				db   = s_r.regs[KD];
			end
			pidc_pkg::PIDC_ST_FG: begin
				skip = !ctl[`PIDC_CTL_DGL];
				da   = {s_r.regs[TS][15:0], 16'h0000};
				db   = {s_r.regs[TS][15:0], 16'h0000} + s_r.tdkd;
			end
			pidc_pkg::PIDC_ST_SQRT: skip = !ctl[`PIDC_CTL_SQRT];
			default: skip = 1'b0;
		endcase
		rem_sh = {s_r.rem[31:0], s_r.num[47]};
		num_sh = {s_r.num[46:0], 1'b0};
		if (rem_sh >= {1'b0, s_r.den}) begin
			rem_sh    = rem_sh - {1'b0, s_r.den};
			num_sh[0] = 1'b1;
		end
		quo  = (num_sh[47:31] != '0) ? 32'h7FFF_FFFF : num_sh[31:0];
		// square root candidate: next result bit tried from the top
		cand = s_r.num[15:0] | (16'h8000 >> s_r.cnt[3:0]);
		sq   = cand * cand;
	end

	////////////////////////////////////////////////////////////////////////////
	// loop calculation for the current sample

	always_comb begin
		err_raw = $signed(sp_eff) - $signed(s_r.pv);
		dev     = qabs(err_raw);
		e1      = ctl[`PIDC_CTL_ERRSQ] ? qmul(err_raw, dev) : err_raw;
		// squaring first, band test on the raw pv distance afterwards
		e = (ctl[`PIDC_CTL_DBAND] && dev < $signed(s_r.regs[DBND])) ? '0 : e1;
		kc = s_r.regs[KC];
		ki = (kc != '0) ? qmul(kc, s_r.ki) : s_r.ki;
		kr = (kc != '0) ? qmul(kc, s_r.kr) : s_r.kr;
		// the filtered pv feeds the derivative term only
		y  = ctl[`PIDC_CTL_DGL] ?
			$signed(s_r.y_prev) + qmul(s_r.fg, $signed(s_r.pv) - $signed(s_r.y_prev)) :
			$signed(s_r.pv);
		dy     = y - $signed(s_r.y_prev);
		pterm  = qmul(kc, e);
		iterm  = qmul(ki, e);
		dterm  = qmul(kr, dy);
		bias_i = ctl[`PIDC_CTL_REVERSE] ? $signed(s_r.regs[BIAS]) - iterm :
			$signed(s_r.regs[BIAS]) + iterm;
		m = ctl[`PIDC_CTL_REVERSE] ? bias_i - pterm + dterm : bias_i + pterm - dterm;
		pd   = m - bias_i;
		outv = clamp01(m);
		if (m == outv)
			bias_n = bias_i;
		else if (ctl[`PIDC_CTL_FREEZE] || s_r.regs[TI] == `PIDC_TI_OFF)
			bias_n = s_r.regs[BIAS];
		else
			bias_n = outv - pd;
		// bias kept in range every sample so windup cannot build
		bias_n = clamp01(bias_n);
		// alarms use this sample's pv and setpoint, with the last states as memory
		al[0] = over(s_r.regs[STS][0], s_r.pv, s_r.regs[HH], s_r.regs[HYS]);
		al[1] = over(s_r.regs[STS][1], s_r.pv, s_r.regs[HI], s_r.regs[HYS]);
		// low limits mirror the high test on negated values
		al[2] = over(s_r.regs[STS][2], -$signed(s_r.pv), -$signed(s_r.regs[LO]),
			s_r.regs[HYS]);
		al[3] = over(s_r.regs[STS][3], -$signed(s_r.pv), -$signed(s_r.regs[LL]),
			s_r.regs[HYS]);
		al[4] = over(s_r.regs[STS][4], dev, s_r.regs[YEL], s_r.regs[HYS]);
		al[5] = over(s_r.regs[STS][5], dev, s_r.regs[ORA], s_r.regs[HYS]);
		al[6] = qabs($signed(s_r.pv) - $signed(s_r.pv_prev)) > $signed(s_r.regs[RATE]);
	end

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_nxt      = s_r;
		s_nxt.done = 1'b0;

		// bus: answer one cycle after the request, write lands on the answer edge
		s_nxt.ack = req & ~s_r.ack;
		if (avs_read_i && !s_r.ack) begin
			if (idx < `PIDC_REG_COUNT)
				s_nxt.rdata = s_r.regs[idx];
			else
				s_nxt.rdata = '0;
		end
		// result registers and everything above them are read only
		if (avs_write_i && s_r.ack) begin
			if (idx < OUTR)
				s_nxt.regs[idx] = merge(s_r.regs[idx], avs_writedata_i, avs_byteenable_i);
		end

		// bumpless transfer out of manual
		s_nxt.mode_prev = mode_of(ctl);
		if (s_r.mode_prev == pidc_pkg::PIDC_MANUAL &&
			(mode_of(ctl) == pidc_pkg::PIDC_AUTO ||
			(mode_of(ctl) == pidc_pkg::PIDC_CASCADE &&
			ctl[`PIDC_CTL_VARIANT]))) begin
			s_nxt.regs[SP] = s_r.pv;
			s_nxt.sp_prev  = s_r.pv;
			if (!ctl[`PIDC_CTL_VELOCITY])
				s_nxt.regs[BIAS] = s_r.regs[OUTR];
		end

		// sample pacing in 1 ms ticks; a zero sample time acts as one tick
		if (tick_end(s_r.tick))
			s_nxt.tick = '0;
		else
			s_nxt.tick = s_r.tick + 32'h0000_0001;

		case (s_r.st)
			pidc_pkg::PIDC_ST_IDLE: begin
				// a sample due during a calculation is dropped, not queued
				if (tick_end(s_r.tick)) begin
					if (s_r.scnt + 32'h0000_0001 >= s_r.regs[TS]) begin
						s_nxt.scnt = '0;
						if (ctl[`PIDC_CTL_ENABLE]) begin
							s_nxt.pv = {16'h0000, process_value_i};
							s_nxt.st = pidc_pkg::PIDC_ST_STEP;
						end
					end else begin
						s_nxt.scnt = s_r.scnt + 32'h0000_0001;
					end
				end
			end
			pidc_pkg::PIDC_ST_SQRT: begin
				if (skip) begin
					s_nxt.st = pidc_pkg::PIDC_ST_CALC;
				end else if (!s_r.busy) begin
					s_nxt.busy = 1'b1;
					s_nxt.cnt  = '0;
					s_nxt.num  = '0;
				end else begin
					if (sq <= {s_r.pv[15:0], 16'h0000})
						s_nxt.num[15:0] = cand;
					s_nxt.cnt = s_r.cnt + 6'h01;
					if (s_r.cnt == `PIDC_SQRT_STEPS) begin
						s_nxt.busy = 1'b0;
						s_nxt.pv   = {16'h0000, s_nxt.num[15:0]};
						s_nxt.st   = pidc_pkg::PIDC_ST_CALC;
					end
				end
			end
			pidc_pkg::PIDC_ST_CALC: begin
				// manual leaves the bias; leaving manual relies on the bumpless load
				if (mode_of(ctl) == pidc_pkg::PIDC_MANUAL) begin
					s_nxt.regs[OUTR] = s_r.regs[MAN];
					s_nxt.regs[INCR] = s_r.regs[MAN] - s_r.regs[OUTR];
				end else begin
					s_nxt.regs[OUTR] = outv;
					s_nxt.regs[BIAS] = bias_n;
					s_nxt.regs[INCR] = outv - $signed(s_r.regs[OUTR]);
				end
				s_nxt.regs[STS][6:0] = al;
				s_nxt.pv_prev        = s_r.pv;
				s_nxt.y_prev         = y;
				s_nxt.sp_prev        = sp_eff;
				s_nxt.done           = 1'b1;
				s_nxt.st             = pidc_pkg::PIDC_ST_IDLE;
			end
			default: begin
				// divider stages: step ratio, ki, kr, td/kd, filter gain
				if (skip) begin
					if (s_r.st == pidc_pkg::PIDC_ST_KI)
						s_nxt.ki = '0;
					if (s_r.st == pidc_pkg::PIDC_ST_KR)
						s_nxt.kr = '0;
					s_nxt.st = pidc_pkg::pidc_state_e'(s_r.st + 3'b001);
				end else if (!s_r.busy) begin
					s_nxt.busy = 1'b1;
					s_nxt.cnt  = '0;
					s_nxt.num  = {da, 16'h0000};
					s_nxt.rem  = '0;
					s_nxt.den  = db;
				end else begin
					s_nxt.num = num_sh;
					s_nxt.rem = rem_sh;
					s_nxt.cnt = s_r.cnt + 6'h01;
					if (s_r.cnt == `PIDC_DIV_STEPS) begin
						s_nxt.busy = 1'b0;
						s_nxt.st   = pidc_pkg::pidc_state_e'(s_r.st + 3'b001);
						case (s_r.st)
							pidc_pkg::PIDC_ST_STEP:
								s_nxt.regs[BIAS] = clamp01(qmul(s_r.regs[BIAS], quo));
							pidc_pkg::PIDC_ST_KI:   s_nxt.ki   = quo;
							pidc_pkg::PIDC_ST_KR:   s_nxt.kr   = quo;
							pidc_pkg::PIDC_ST_TDKD: s_nxt.tdkd = quo;
							default:                s_nxt.fg   = quo;
						endcase
					end
				end
			end
		endcase
		s_nxt.regs[STS][`PIDC_STS_BUSY] = s_nxt.st != pidc_pkg::PIDC_ST_IDLE;

		if (sys_rst_i) begin
			s_nxt          = '0;
			s_nxt.regs[TS] = `PIDC_RST_TS;
			s_nxt.regs[TI] = `PIDC_RST_TI;
			s_nxt.regs[KD] = `PIDC_RST_KD;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		s_r <= s_nxt;
	end

endmodule // pidc_loop_calc
`default_nettype wire

// ==== test/pidc_loop_calc_assertions.sv ====
// port checker of the pid loop calculation unit
`default_nettype none
module pidc_loop_calc_chk #(
	parameter int unsigned TICK_CYCLES = 8
) (
	input wire logic        ref_clk_i,          // clock
	input wire logic        sys_rst_i,          // reset, high
	input wire logic [7:0]  avs_address_i,      // byte address
	input wire logic        avs_read_i,         // read request
	input wire logic        avs_write_i,        // write request
	input wire logic [31:0] avs_writedata_i,    // write data
	input wire logic [3:0]  avs_byteenable_i,   // byte lanes
	input wire logic [31:0] avs_readdata_o,     // read data
	input wire logic        avs_waitrequest_o,  // stall
	input wire logic [15:0] process_value_i,    // sensor value
	input wire logic [31:0] cascade_setpoint_i, // cascade setpoint
	input wire logic [31:0] control_output_o,   // position output
	input wire logic [31:0] output_increment_o, // output change
	input wire logic [6:0]  alarms_o,           // alarm levels
	input wire logic        sample_done_o       // calculation pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] gap_r;
	logic [31:0] gap_nxt;

	// saturates, so the first pulse after reset always sees a wide gap
	always_comb begin
		gap_nxt = (gap_r == 32'hFFFF_FFFF) ? gap_r : gap_r + 32'h0000_0001;
		if (sample_done_o) gap_nxt = 32'h0000_0001;
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) gap_r <= 32'hFFFF_FFFF;
		else gap_r <= gap_nxt;
	end

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);

	////////////////////////////////////////////////////////////////////////////////
	sequence bus_req_s;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	sequence bus_ans_s;
		!avs_waitrequest_o;
	endsequence

	bus_wait_a: assert property (bus_req_s |=> bus_ans_s)
		else $error("waitrequest held past one cycle");
	bus_idle_a: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
		else $error("waitrequest without request");
	bus_first_a: assert property ($rose(avs_read_i) |-> avs_waitrequest_o)
		else $error("read answered without wait cycle");
	unmap_zero_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i >= 8'h54
		|-> avs_readdata_o == 32'h0000_0000) else $error("unmapped read not zero");
	rdata_hold_a: assert property (!avs_read_i |=> $stable(avs_readdata_o))
		else $error("read data moved without read");

	////////////////////////////////////////////////////////////////////////////////
	done_pulse_a: assert property (sample_done_o |=> !sample_done_o)
		else $error("sample done longer than one cycle");
	done_gap_a: assert property (sample_done_o |-> gap_r >= TICK_CYCLES)
		else $error("two calculations in one period");
	out_clamp_a: assert property (control_output_o <= 32'h0001_0000)
		else $error("output above one");
	out_hold_a: assert property (!sample_done_o |-> $stable(control_output_o)
		&& $stable(output_increment_o)) else $error("output moved between samples");
	alarm_hold_a: assert property (!sample_done_o |-> $stable(alarms_o))
		else $error("alarm moved between samples");
endmodule // pidc_loop_calc_chk

bind pidc_loop_calc pidc_loop_calc_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
	.ref_clk_i, .sys_rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
	.avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
	.process_value_i, .cascade_setpoint_i, .control_output_o, .output_increment_o,
	.alarms_o, .sample_done_o
);
`default_nettype wire

// ==== test/pidc_ana_model.sv ====
// analog input and output module model facing the loop unit
`default_nettype none
module pidc_ana_model (
	input  wire logic        clk_i,    // clock
	input  wire logic        rst_i,    // reset, high
	input  wire logic [15:0] level_i,  // sensor level
	input  wire logic [31:0] drive_i,  // control output
	input  wire logic        strobe_i, // new output ready
	output logic      [15:0] pv_o,     // converted sensor value
	output logic      [31:0] act_o     // actuator setting
);
	timeunit 1ns;
	timeprecision 1ps;
	// one cycle of converter latency; the actuator moves only on a finished sample
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pv_o  <= 16'h0000;
			act_o <= 32'h0000_0000;
		end else begin
			pv_o <= level_i;
			if (strobe_i) act_o <= drive_i;
		end
	end
endmodule // pidc_ana_model
`default_nettype wire

// ==== test/tb.sv ====
// self-checking bench of the pid loop calculation unit
`include "pidc_cfg.svh"
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk;
	logic        rst;
	logic        rd;
	logic        wr;
	logic [7:0]  adr;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic        wreq;
	logic [15:0] pv_tgt;
	logic [15:0] pv;
	logic [31:0] csp;
	logic [31:0] cout;
	logic [31:0] incr;
	logic [31:0] act;
	logic [6:0]  alm;
	logic        done;
	int          error_cnt = 0;
	int          cmp_count = 0;

	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end

	// short tick keeps the run small; sample spacing comes from TS instead
	pidc_loop_calc #(.TICK_CYCLES(8)) DUT (
		.ref_clk_i(clk), .sys_rst_i(rst), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .process_value_i(pv),
		.cascade_setpoint_i(csp), .control_output_o(cout), .output_increment_o(incr),
		.alarms_o(alm), .sample_done_o(done)
	);

	pidc_ana_model u_ana (
		.clk_i(clk), .rst_i(rst), .level_i(pv_tgt), .drive_i(cout),
		.strobe_i(done), .pv_o(pv), .act_o(act)
	);

	task automatic finish_test;
		if (error_cnt == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		logic wt;
		int   n;
		@(posedge clk);
		adr  <= a;
		wdat <= d;
		wr   <= w;
		rd   <= !w;
		wt = 1'h1;
		n = 0;
		while (wt !== 1'h0 && n < 50) begin
			@(posedge clk);
			wt = wreq;
			q = rdat;
			n++;
		end
		check({31'h0, wt}, 32'h0000_0000);
		wr <= 1'h0;
		rd <= 1'h0;
	endtask

	task automatic wrr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'h1, a, d, q);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'h0, a, 32'h0000_0000, q);
		check(q, e);
	endtask

	// leaves the bench just after the edge that follows the pulse
	task automatic wait_done(input int k);
		int n;
		repeat (k) begin
			n = 0;
			do begin
				@(negedge clk);
				n++;
			end while (done !== 1'h1 && n < 2000);
			check({31'h0, done}, 32'h0000_0001);
			@(posedge clk);
		end
	endtask

	task automatic set_pv(input logic [15:0] v, input int k);
		pv_tgt <= v;
		wait_done(k);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		rdc(`PIDC_OFS_TS, 32'h0000_0001);
		rdc(`PIDC_OFS_TI, 32'h0000_270F);
		rdc(`PIDC_OFS_KD, 32'h0001_0000);
		rdc(`PIDC_OFS_CTRL, 32'h0000_0000);
		wrr(`PIDC_OFS_OUTPUT, 32'h1234_5678);
		rdc(`PIDC_OFS_OUTPUT, 32'h0000_0000);
		rdc(8'h54, 32'h0000_0000);
		wrr(`PIDC_OFS_GAIN, 32'h0002_0000);
		rdc(`PIDC_OFS_GAIN, 32'h0002_0000);
		wrr(`PIDC_OFS_GAIN, 32'h0000_0000);
	endtask

	task automatic t_manual_alarms;
		wrr(`PIDC_OFS_HH, 32'h0000_8000);
		wrr(`PIDC_OFS_H, 32'h0000_4000);
		wrr(`PIDC_OFS_L, 32'h0000_2000);
		wrr(`PIDC_OFS_LL, 32'h0000_1000);
		wrr(`PIDC_OFS_YELLOW, 32'h0000_1000);
		wrr(`PIDC_OFS_ORANGE, 32'h0000_2000);
		wrr(`PIDC_OFS_RATE, 32'h0001_0000);
		wrr(`PIDC_OFS_HYST, 32'h0000_1000);
		wrr(`PIDC_OFS_MANUAL, 32'h0000_8000);
		wrr(`PIDC_OFS_TS, 32'h0000_0032);
		pv_tgt <= 16'hC000;
		wrr(`PIDC_OFS_CTRL, 32'h0000_0001);
		wait_done(2);
		check(cout, 32'h0000_8000);
		check(act, 32'h0000_8000);
		check({25'h0, alm}, 32'h0000_0033);
		set_pv(16'h7800, 2);
		check({25'h0, alm}, 32'h0000_0033);
		set_pv(16'h6000, 2);
		check({25'h0, alm}, 32'h0000_0032);
		wrr(`PIDC_OFS_RATE, 32'h0000_1000);
		set_pv(16'h9000, 1);
		check({25'h0, alm}, 32'h0000_0073);
		wait_done(1);
		check({25'h0, alm}, 32'h0000_0033);
		set_pv(16'h0800, 2);
		check({25'h0, alm}, 32'h0000_001C);
		set_pv(16'h6000, 2);
	endtask

	task automatic t_bumpless;
		wrr(`PIDC_OFS_CTRL, 32'h0000_0003);
		repeat (2) @(posedge clk);
		rdc(`PIDC_OFS_SETPOINT, 32'h0000_6000);
		rdc(`PIDC_OFS_BIAS, 32'h0000_8000);
		wait_done(2);
		check(cout, 32'h0000_8000);
	endtask

	task automatic t_prop;
		wrr(`PIDC_OFS_GAIN, 32'h0002_0000);
		wait_done(1);
		set_pv(16'h5000, 1);
		check(cout, 32'h0000_A000);
		wrr(`PIDC_OFS_CTRL, 32'h0000_000B);
		wait_done(2);
		check(cout, 32'h0000_6000);
		wrr(`PIDC_OFS_CTRL, 32'h0000_0003);
		set_pv(16'h0000, 2);
		check(cout, 32'h0001_0000);
		rdc(`PIDC_OFS_BIAS, 32'h0000_8000);
	endtask

	task automatic t_velocity;
		wrr(`PIDC_OFS_CTRL, 32'h0000_0013);
		set_pv(16'h5000, 2);
		check(cout, 32'h0000_A000);
		set_pv(16'h5800, 1);
		check(cout, 32'h0000_9000);
		check(incr, 32'hFFFF_F000);
	endtask

	task automatic t_cascade;
		csp <= 32'h0000_7000;
		wrr(`PIDC_OFS_CTRL, 32'h0000_0005);
		set_pv(16'h5000, 2);
		check(cout, 32'h0000_C000);
	endtask

	task automatic t_err_shape;
		wrr(`PIDC_OFS_CTRL, 32'h0000_0103);
		set_pv(16'h4000, 2);
		check(cout, 32'h0000_8800);
		wrr(`PIDC_OFS_DBAND, 32'h0000_1000);
		wrr(`PIDC_OFS_CTRL, 32'h0000_0203);
		set_pv(16'h5800, 2);
		check(cout, 32'h0000_8000);
		set_pv(16'h5000, 2);
		check(cout, 32'h0000_A000);
		wrr(`PIDC_OFS_CTRL, 32'h0000_0303);
		set_pv(16'h4000, 2);
		check(cout, 32'h0000_8800);
	endtask

	task automatic t_special;
		wrr(`PIDC_OFS_CTRL, 32'h0000_0083);
		wait_done(2);
		check(cout, 32'h0000_4000);
		pv_tgt <= 16'h0000;
		wrr(`PIDC_OFS_CTRL, 32'h0000_0023);
		wrr(`PIDC_OFS_TI, 32'h0000_0032);
		wait_done(2);
		rdc(`PIDC_OFS_BIAS, 32'h0000_8000);
		wrr(`PIDC_OFS_CTRL, 32'h0000_0003);
		wait_done(2);
		rdc(`PIDC_OFS_BIAS, 32'h0000_4000);
		wrr(`PIDC_OFS_TI, 32'h0000_270F);
		wrr(`PIDC_OFS_CTRL, 32'h0000_0043);
		wrr(`PIDC_OFS_SETPOINT, 32'h0000_3000);
		wait_done(2);
		check(cout, 32'h0000_8000);
		rdc(`PIDC_OFS_BIAS, 32'h0000_2000);
		wrr(`PIDC_OFS_CTRL, 32'h0000_0801);
		wait_done(1);
		wrr(`PIDC_OFS_CTRL, 32'h0000_0805);
		rdc(`PIDC_OFS_SETPOINT, 32'h0000_0000);
		rdc(`PIDC_OFS_BIAS, 32'h0000_8000);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#200_000;
		error_cnt++;
		$display("mismatch at %0t: run did not complete", $time);
		finish_test;
	end

	initial begin
		rst = 1'h1;
		rd = 1'h0;
		wr = 1'h0;
		adr = 8'h00;
		wdat = 32'h0000_0000;
		pv_tgt = 16'h0000;
		csp = 32'h0000_0000;
		repeat (16) @(posedge clk);
		rst <= 1'h0;
		t_regs;
		t_manual_alarms;
		t_bumpless;
		t_prop;
		t_velocity;
		t_cascade;
		t_err_shape;
		t_special;
		finish_test;
	end
endmodule // tb
`default_nettype wire
